/* File: design/rir_cfg_field.sv */
/*
 * rir_cfg_field: one writable register field with a constant reset value.
 * Assumes a single-cycle write strobe synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module rir_cfg_field #(
	parameter int             W     = 8,
	parameter logic [W-1:0]   RST_V = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	output var  logic [W-1:0] q
);

	// -------------------------------------------------------------
	// storage
	// -------------------------------------------------------------
	// field holds its reset value until software writes it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= RST_V;
		end else if (wr_en) begin
			q <= wr_data;
		end
	end

endmodule

`default_nettype wire

/* File: design/rir_pkg.sv */
/*
 * rir_pkg: offsets, field layouts, reset values and selector codes of the
 * remote interrupt routing and splitter line width register slice.
 * Assumes byte-wide registers on an eight-bit register address.
 */
package rir_pkg;

	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] ADDR_REMOTE_IRQ_ROUTE_CTRL  = 8'h30;
	localparam logic [7:0] ADDR_SPLIT_LINE_WIDTH_LOW   = 8'h32;
	localparam logic [7:0] ADDR_SPLIT_LINE_WIDTH_HIGH  = 8'h33;

	// -------------------------------------------------------------
	// field widths and reset values
	// -------------------------------------------------------------
	localparam int         SEL_W        = 4;
	localparam int         LOW_W        = 8;
	localparam int         HIGH_W       = 5;
	localparam int         LW_W         = LOW_W + HIGH_W;
	localparam int         GPIO_N       = 4;
	localparam logic [3:0] SEL_RESET    = 4'h0;
	localparam logic [7:0] LOW_RESET    = 8'h00;
	localparam logic [4:0] HIGH_RESET   = 5'h05;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// -------------------------------------------------------------
	// selector codes (upper two bits pick the group, low two the pin)
	// -------------------------------------------------------------
	localparam logic [3:0] SEL_OFF       = 4'h0;
	localparam logic [3:0] SEL_PER_PORT  = 4'h1;
	localparam logic [1:0] GRP_GPIO      = 2'h2;
	localparam logic [1:0] GRP_ALT_GPIO  = 2'h3;

endpackage

/* File: design/rir_remote_irq_route_line_size.sv */
/*
 * rir_remote_irq_route_line_size: remote interrupt pin routing and the
 * splitter line width value, reached over a byte register port that the
 * serial control port logic drives.
 * Assumes link interrupts and port status are synchronous to clk and that
 * interrupts are active high here; pin polarity is handled at the pads.
 * Assumes the register port pulses reg_wr or reg_rd for one cycle per
 * access and does not write and read one address in the same cycle; such
 * a read returns the value from before the write.
 * The *_en outputs tell the pad ring which gpio pin the routed interrupt
 * has taken; pins not taken keep their normal function.
 * Line width outputs are not clamped: the splitter sees what was written,
 * and keeping it at or below 4096 is up to software.
 * Reserved selector codes are stored and read back but route nothing.
 * Everything runs on clk and takes its reset value on rst; there is no other clock
 * domain and no interrupt state of its own in here.
 */
`timescale 1ns/10ps
`default_nettype none

module rir_remote_irq_route_line_size (
	input  wire logic                        clk,
	input  wire logic                        rst,
	// byte register port
	input  wire logic [7:0]                  reg_addr,
	input  wire logic [7:0]                  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output var  logic [7:0]                  reg_rdata,
	output var  logic                        reg_rvalid,
	// link side status
	input  wire logic                        link_irq_p0,
	input  wire logic                        link_irq_p1,
	input  wire logic                        port0_active,
	input  wire logic                        port1_active,
	input  wire logic                        dual_link_mode,
	input  wire logic                        local_irq_src,
	// interrupt pins
	output var  logic                        remote_irq_out,
	output var  logic                        local_irq_out,
	output var  logic [rir_pkg::GPIO_N-1:0]  gpio_irq,
	output var  logic [rir_pkg::GPIO_N-1:0]  gpio_irq_en,
	output var  logic [rir_pkg::GPIO_N-1:0]  alt_gpio_irq,
	output var  logic [rir_pkg::GPIO_N-1:0]  alt_gpio_irq_en,
	// splitter configuration
	output var  logic [rir_pkg::LW_W-1:0]    split_line_width,
	output var  logic [rir_pkg::LW_W:0]      split_input_line_width,
	output var  logic [rir_pkg::LW_W-1:0]    dual_input_line_width
);

	// -------------------------------------------------------------
	// register decode
	// -------------------------------------------------------------
	logic                        sel_hit;
	logic                        low_hit;
	logic                        high_hit;
	logic [rir_pkg::SEL_W-1:0]   remote_irq_pin_select;
	logic [rir_pkg::LOW_W-1:0]   lw_low;
	logic [rir_pkg::HIGH_W-1:0]  lw_high;
	logic [rir_pkg::LW_W-1:0]    lw_value;

	// address compare for the three mapped registers
	always_comb begin
		sel_hit  = 1'b0;
		low_hit  = 1'b0;
		high_hit = 1'b0;
		if (reg_addr == rir_pkg::ADDR_REMOTE_IRQ_ROUTE_CTRL) begin
			sel_hit = 1'b1;
		end else if (reg_addr == rir_pkg::ADDR_SPLIT_LINE_WIDTH_LOW) begin
			low_hit = 1'b1;
		end else if (reg_addr == rir_pkg::ADDR_SPLIT_LINE_WIDTH_HIGH) begin
			high_hit = 1'b1;
		end
	end

	// -------------------------------------------------------------
	// register fields
	// -------------------------------------------------------------
	// selector keeps only its low nibble, upper bits dropped
	rir_cfg_field #(
		.W     (rir_pkg::SEL_W),
		.RST_V (rir_pkg::SEL_RESET)
	) u_sel (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr && sel_hit),
		.wr_data (reg_wdata[rir_pkg::SEL_W-1:0]),
		.q       (remote_irq_pin_select)
	);

	// low byte of the line width, resets to zero
	rir_cfg_field #(
		.W     (rir_pkg::LOW_W),
		.RST_V (rir_pkg::LOW_RESET)
	) u_low (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr && low_hit),
		.wr_data (reg_wdata),
		.q       (lw_low)
	);

	// upper five bits of the line width, resets to five
	rir_cfg_field #(
		.W     (rir_pkg::HIGH_W),
		.RST_V (rir_pkg::HIGH_RESET)
	) u_high (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr && high_hit),
		.wr_data (reg_wdata[rir_pkg::HIGH_W-1:0]),
		.q       (lw_high)
	);

	assign lw_value = {lw_high, lw_low};

	// -------------------------------------------------------------
	// read path
	// -------------------------------------------------------------
	logic [7:0]                  rdata_next;

	// read mux; reserved bits and unmapped addresses give zero
	always_comb begin
		rdata_next = rir_pkg::READ_UNMAPPED;
		if (sel_hit) begin
			rdata_next = {{(8-rir_pkg::SEL_W){1'b0}},
			              remote_irq_pin_select};
		end else if (low_hit) begin
			rdata_next = lw_low;
		end else if (high_hit) begin
			rdata_next = {{(8-rir_pkg::HIGH_W){1'b0}}, lw_high};
		end
	end

	// read data is registered and held until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= rir_pkg::READ_UNMAPPED;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end

	// read answer strobe, one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// -------------------------------------------------------------
	// interrupt routing
	// -------------------------------------------------------------
	logic                        combined_irq;
	logic                        remote_next;
	logic                        local_next;
	logic [rir_pkg::GPIO_N-1:0]  gpio_next;
	logic [rir_pkg::GPIO_N-1:0]  gpio_en_next;
	logic [rir_pkg::GPIO_N-1:0]  alt_next;
	logic [rir_pkg::GPIO_N-1:0]  alt_en_next;
	logic [1:0]                  sel_grp;
	logic [1:0]                  sel_pin;

	assign sel_grp = remote_irq_pin_select[3:2];
	assign sel_pin = remote_irq_pin_select[1:0];

	// merged interrupt of the active ports; dual link is one logical link
	always_comb begin
		if (dual_link_mode) begin
			combined_irq = link_irq_p0;
		end else begin
			combined_irq = (port0_active && link_irq_p0)
			             || (port1_active && link_irq_p1);
		end
	end

	// remote pin carries port 0 only in per-port mode, idle otherwise
	always_comb begin
		remote_next = 1'b0;
		if (remote_irq_pin_select == rir_pkg::SEL_OFF) begin
			remote_next = 1'b0;
		end else if (remote_irq_pin_select == rir_pkg::SEL_PER_PORT) begin
			remote_next = link_irq_p0;
		end
	end

	// local pin adds port 1 in per-port mode, own source otherwise
	always_comb begin
		local_next = local_irq_src;
		if (remote_irq_pin_select == rir_pkg::SEL_PER_PORT) begin
			local_next = local_irq_src || link_irq_p1;
		end
	end

	// gpio group takes the merged interrupt on the selected pin
	always_comb begin
		gpio_next    = '0;
		gpio_en_next = '0;
		if (sel_grp == rir_pkg::GRP_GPIO) begin
			gpio_en_next[sel_pin] = 1'b1;
			gpio_next[sel_pin]    = combined_irq;
		end
	end

	// alternate group, same scheme; reserved codes route nothing
	always_comb begin
		alt_next    = '0;
		alt_en_next = '0;
		if (sel_grp == rir_pkg::GRP_ALT_GPIO) begin
			alt_en_next[sel_pin] = 1'b1;
			alt_next[sel_pin]    = combined_irq;
		end
	end

	// remote pin flop, one cycle behind its sources
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remote_irq_out <= 1'b0;
		end else begin
			remote_irq_out <= remote_next;
		end
	end

	// local pin flop, one cycle behind its sources
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			local_irq_out <= 1'b0;
		end else begin
			local_irq_out <= local_next;
		end
	end

	// gpio group value and pin-taken flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gpio_irq    <= '0;
			gpio_irq_en <= '0;
		end else begin
			gpio_irq    <= gpio_next;
			gpio_irq_en <= gpio_en_next;
		end
	end

	// alternate gpio group value and pin-taken flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alt_gpio_irq    <= '0;
			alt_gpio_irq_en <= '0;
		end else begin
			alt_gpio_irq    <= alt_next;
			alt_gpio_irq_en <= alt_en_next;
		end
	end

	// -------------------------------------------------------------
	// splitter line width outputs
	// -------------------------------------------------------------
	// 2D line width; no clamp, software keeps to 4096
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			split_line_width <= {rir_pkg::HIGH_RESET, rir_pkg::LOW_RESET};
		end else begin
			split_line_width <= lw_value;
		end
	end

	// combined 3D input line, twice the 2D width
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			split_input_line_width <= {rir_pkg::HIGH_RESET,
			                           rir_pkg::LOW_RESET, 1'b0};
		end else begin
			split_input_line_width <= {lw_value, 1'b0};
		end
	end

	// dual-input left/right line width, same value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dual_input_line_width <= {rir_pkg::HIGH_RESET, rir_pkg::LOW_RESET};
		end else begin
			dual_input_line_width <= lw_value;
		end
	end

endmodule

`default_nettype wire

/* File: dv/rir_host_model.sv */
/* rir_host_model: host side of the byte register port.
   Assumes calls start just after a rising clk edge. */
`timescale 1ns/10ps
`default_nettype none
module rir_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	output var  logic       reg_wr,
	output var  logic       reg_rd
);
	// idle port at time zero
	initial begin
		{reg_addr, reg_wdata} = 16'h0000;
		{reg_wr, reg_rd} = 2'h0;
	end
	// one write, released lines show inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
		@(posedge clk);
	endtask
	// one read, answer awaited at most four cycles
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		{reg_addr, reg_rd} <= {~a, 1'b0};
		ok = 1'b0;
		d = 8'h00;
		// the answer stands for the cycle after the taking edge
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk);
			ok = reg_rvalid;
			d = reg_rdata;
		end
	endtask
endmodule
`default_nettype wire

/* File: dv/rir_remote_irq_route_line_size_bench.sv */
/* rir_remote_irq_route_line_size_bench: self-checking bench.
   Assumes the host model drives the register port. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) chk(n, 16'(e), 16'(a))
module rir_remote_irq_route_line_size_bench;
	logic        clk, rst, link_irq_p0, link_irq_p1, dual_link_mode;
	logic        port0_active, port1_active, local_irq_src, ok;
	logic        reg_wr, reg_rd, reg_rvalid, remote_irq_out, local_irq_out;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [3:0]  gpio_irq, gpio_irq_en, alt_gpio_irq, alt_gpio_irq_en;
	logic [12:0] split_line_width, dual_input_line_width;
	logic [13:0] split_input_line_width;
	int          bad_count = 0;
	int          checks_done = 0;
	rir_remote_irq_route_line_size i_dut (.*);
	rir_host_model i_host (.*);
	always #20 clk = ~clk;
	// compare and count
	task automatic chk(string n, logic [15:0] e, logic [15:0] a);
		checks_done++;
		if (a !== e) begin
			bad_count++;
			$display("BAD %s exp %0h got %0h", n, e, a);
		end
	endtask
	// one read with its answer checked; a missing answer ends the run
	task automatic rd_reg(input logic [7:0] a);
		i_host.rd(a, d, ok);
		`CHK("rvalid", 1'b1, ok);
		if (!ok) begin
			stop_test();
		end
	endtask
	// reset values and reads of the whole window
	task automatic t_reset;
		`CHK("width", 13'h0500, split_line_width);
		`CHK("pins", 10'h000, {remote_irq_out, local_irq_out, gpio_irq_en, alt_gpio_irq_en});
		`CHK("in_width", 14'h0A00, split_input_line_width);
		for (int i = 0; i < 4; i++) begin
			rd_reg(8'h30 + 8'(i));
			`CHK("rst_rd", (i == 3) ? 8'h05 : 8'h00, d);
		end
	endtask
	// both bytes, masking, no clamp, unmapped write
	task automatic t_width;
		i_host.wr(8'h32, 8'hFF);
		i_host.wr(8'h33, 8'hFF);
		i_host.wr(8'h31, 8'hA5);
		rd_reg(8'h33);
		`CHK("high_rd", 8'h1F, d);
		`CHK("width", 13'h1FFF, split_line_width);
		`CHK("dual_width", 13'h1FFF, dual_input_line_width);
		`CHK("in_width", 14'h3FFE, split_input_line_width);
		rd_reg(8'h31);
		`CHK("unmapped", 8'h00, d);
	endtask
	// every legal selector code against four input sets
	task automatic t_route;
		logic [3:0] c, en, eg, ea;
		logic       m;
		for (int k = 0; k < 10; k++) begin
			c = (k < 2) ? 4'(k) : 4'(k + 6);
			i_host.wr(8'h30, {4'hF, c});
			rd_reg(8'h30);
			`CHK("sel_rd", {4'h0, c}, d);
			en = 4'h1 << c[1:0];
			eg = (c[3:2] == 2'h2) ? en : 4'h0;
			ea = (c[3:2] == 2'h3) ? en : 4'h0;
			for (int v = 0; v < 4; v++) begin
				@(posedge clk);
				{link_irq_p0, link_irq_p1} <= {v == 0 || v == 3, v != 0};
				{dual_link_mode, port0_active} <= {v == 2, v != 3};
				port1_active <= (v != 3);
				local_irq_src <= (v == 3);
				repeat (2) @(posedge clk);
				#1;
				m = (v < 2);
				`CHK("remote", c == 1 && v != 1 && v != 2, remote_irq_out);
				`CHK("local", v == 3 || (c == 1 && v != 0), local_irq_out);
				`CHK("gpio", {eg, m ? eg : 4'h0}, {gpio_irq_en, gpio_irq});
				`CHK("alt", {ea, m ? ea : 4'h0}, {alt_gpio_irq_en, alt_gpio_irq});
			end
		end
	endtask
	// verdict and end of run
	task automatic stop_test;
		if (bad_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{clk, rst, link_irq_p0, link_irq_p1, dual_link_mode} = 5'h08;
		{port0_active, port1_active, local_irq_src} = 3'h6;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_width();
		t_route();
		stop_test();
	end
endmodule
`default_nettype wire

/* File: dv/rir_route_monitor.sv */
/* rir_route_monitor: port assertions for irq routing and line width.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module rir_route_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        link_irq_p0,
	input wire logic        link_irq_p1,
	input wire logic        port0_active,
	input wire logic        port1_active,
	input wire logic        dual_link_mode,
	input wire logic        local_irq_src,
	input wire logic        remote_irq_out,
	input wire logic        local_irq_out,
	input wire logic [3:0]  gpio_irq,
	input wire logic [3:0]  gpio_irq_en,
	input wire logic [3:0]  alt_gpio_irq,
	input wire logic [3:0]  alt_gpio_irq_en,
	input wire logic [12:0] split_line_width,
	input wire logic [13:0] split_input_line_width,
	input wire logic [12:0] dual_input_line_width
);
	logic [3:0] sel_q;
	logic       cmb;
	// combined remote interrupt of the active ports, port 0 alone in dual link mode
	assign cmb = dual_link_mode ? link_irq_p0 :
		(port0_active & link_irq_p0) | (port1_active & link_irq_p1);
	// selector mirror as written through the port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_q <= 4'h0;
		end else if (reg_wr && reg_addr == 8'h30) begin
			sel_q <= reg_wdata[3:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_off_quiet: assert property ($past(sel_q) == 4'h0 |->
		!remote_irq_out) else $error("remote irq while off");
	a_gpio_idle: assert property ($past(sel_q) < 4'h8 |->
		(gpio_irq_en | alt_gpio_irq_en) == 4'h0) else $error("gpio taken");
	a_port_split: assert property ($past(sel_q) == 4'h1 |->
		remote_irq_out == $past(link_irq_p0) && local_irq_out ==
		($past(link_irq_p1) | $past(local_irq_src))) else $error("split");
	a_gpio_route: assert property (($past(sel_q) >> 2) == 4'h2 |->
		gpio_irq_en == (4'h1 << ($past(sel_q) & 4'h3)) &&
		gpio_irq == ($past(cmb) ? gpio_irq_en : 4'h0)) else $error("gpio");
	a_alt_route: assert property (($past(sel_q) >> 2) == 4'h3 |->
		alt_gpio_irq_en == (4'h1 << ($past(sel_q) & 4'h3)) &&
		alt_gpio_irq == ($past(cmb) ? alt_gpio_irq_en : 4'h0))
		else $error("alt gpio");
	a_low_write: assert property (reg_wr && reg_addr == 8'h32 |->
		##2 split_line_width[7:0] == $past(reg_wdata, 2))
		else $error("low width byte");
	a_high_write: assert property (reg_wr && reg_addr == 8'h33 |->
		##2 split_line_width[12:8] == $past(reg_wdata[4:0], 2))
		else $error("high width bits");
	a_width_derived: assert property (
		split_input_line_width == {split_line_width, 1'b0} &&
		dual_input_line_width == split_line_width) else $error("widths");
endmodule
bind rir_remote_irq_route_line_size rir_route_monitor i_mon (.*);
`default_nettype wire
